// ### hdl/sew_write_engine.sv
// two-wire eeprom target, write side: byte, page, parameter page and lock
// ----------------------------------------
`timescale 1ns/1ps
`include "sew_defines.svh"
module sew_write_engine #(
	parameter int PROG_CYCLES = `SEW_PROG_CYCLES
) (
	input  wire logic        clock_i,
	input  wire logic        sys_rst_i,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	input  wire logic        strap_address_bit0_i,
	input  wire logic        strap_address_bit1_i,
	input  wire logic        strap_address_bit2_i,
	input  wire logic        write_guard_i,
	input  wire logic        lock_state_i,
	output logic             busy_o,
	output logic             nv_valid_o,
	input  wire logic        nv_ready_i,
	output sew_pkg::sew_wr_t nv_word_o
);
	import sew_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic dev_match(input logic [7:0] b, input logic [2:0] strap);
		logic [3:0] ty;
		ty = b[`SEW_TYPE_MSB:`SEW_TYPE_LSB];
		return ((ty == `SEW_TYPE_ARRAY) || (ty == `SEW_TYPE_PARAM)) &&
			(b[3:1] == strap) && !b[`SEW_RW_BIT];
	endfunction : dev_match

	function automatic logic [13:0] page_inc(input logic [13:0] a);
		return {a[13:6], 6'(a[5:0] + 6'h1)};
	endfunction : page_inc

	sew_eng_t q;
	sew_eng_t next_q;
	logic     scl_rise;
	logic     scl_fall;
	logic     start_evt;
	logic     stop_evt;
	logic     byte_done;
	logic     launchable;
	logic     guard;
	logic     push_valid;
	logic     push_ready;
	sew_wr_t  push_word;
	logic     prog_done;

	// ----------------------------------------
	// bus events, taken from the second sync stage and its delayed copy
	// ----------------------------------------
	assign scl_rise   = q.scl_s2 & ~q.scl_d;
	assign scl_fall   = ~q.scl_s2 & q.scl_d;
	assign start_evt  = q.scl_s2 & q.scl_d & q.sda_d & ~q.sda_s2;
	assign stop_evt   = q.scl_s2 & q.scl_d & ~q.sda_d & q.sda_s2;
	assign byte_done  = scl_fall && (q.bitcnt == `SEW_BYTE_BITS);
	assign launchable = (|q.mask) | q.lock_arm;
	assign guard      = q.pin_s2[3];

	// ----------------------------------------
	// program sequencer feeding the buffer
	// ----------------------------------------
	assign push_valid = (q.st == SEW_PROG) &&
		(q.lock_arm || (!q.idx[6] && q.mask[q.idx[5:0]]));
	always_comb begin
		push_word.kind = q.lock_arm ? SEW_K_LOCK : q.kind;
		push_word.addr = {q.addr[13:6], q.idx[5:0]};
		push_word.data = q.lock_arm ? 8'h02 : q.page[q.idx[5:0]];
	end
	// words still go to the array after the timer has stopped at its end count; a slow port stretches the cycle
	assign prog_done = (q.tmr == 24'(PROG_CYCLES - 1)) && q.idx[6] && !q.lock_arm;

	sew_buf2 u_buf (
		.clock_i     (clock_i),
		.sys_rst_i   (sys_rst_i),
		.in_valid_i  (push_valid),
		.in_ready_o  (push_ready),
		.in_word_i   (push_word),
		.out_valid_o (nv_valid_o),
		.out_ready_i (nv_ready_i),
		.out_word_o  (nv_word_o)
	);

	// ----------------------------------------
	// protocol engine
	// ----------------------------------------
	always_comb begin
		next_q        = q;
		next_q.scl_s1 = scl_i;
		next_q.scl_s2 = q.scl_s1;
		next_q.scl_d  = q.scl_s2;
		next_q.sda_s1 = sda_i;
		next_q.sda_s2 = q.sda_s1;
		next_q.sda_d  = q.sda_s2;
		next_q.pin_s1 = {write_guard_i, strap_address_bit2_i, strap_address_bit1_i,
			strap_address_bit0_i};
		next_q.pin_s2 = q.pin_s1;
		if (q.st == SEW_PROG) begin
			// bus is deaf here: starts, stops and bytes all dropped
			if (q.tmr != 24'(PROG_CYCLES - 1)) begin
				next_q.tmr = 24'(q.tmr + 24'h1);
			end
			if (q.lock_arm) begin
				if (push_ready) begin
					next_q.lock_arm = 1'b0;
				end
			end else if (!q.idx[6] && (!q.mask[q.idx[5:0]] || push_ready)) begin
				next_q.idx = 7'(q.idx + 7'h1);
			end
			if (prog_done) begin
				next_q.st   = SEW_IDLE;
				next_q.mask = '0;
			end
		end else if (start_evt) begin
			next_q.st       = SEW_DEVADDR;
			next_q.bitcnt   = 4'h0;
			next_q.drive    = 1'b0;
			next_q.mask     = '0;
			next_q.lock_arm = 1'b0;
		end else if (stop_evt) begin
			next_q.drive = 1'b0;
			// a stop needs scl high, so the tenth rise has already shifted in a low bit
			if (q.st == SEW_DATA && q.bitcnt == 4'h1 && !q.shift[0] && launchable) begin
				next_q.st  = SEW_PROG;
				next_q.idx = 7'h0;
				next_q.tmr = 24'h0;
			end else begin
				next_q.st       = SEW_IDLE;
				next_q.mask     = '0;
				next_q.lock_arm = 1'b0;
			end
		end else begin
			unique case (q.st)
				SEW_IDLE: begin
				end
				SEW_DEVADDR, SEW_ADDR_HI, SEW_ADDR_LO, SEW_DATA: begin
					if (scl_rise && q.bitcnt != `SEW_BYTE_BITS) begin
						next_q.shift  = {q.shift[6:0], q.sda_s2};
						next_q.bitcnt = 4'(q.bitcnt + 4'h1);
					end else if (byte_done) begin
						next_q.ack_go = 1'b1;
						unique case (q.st)
							SEW_DEVADDR: begin
								next_q.ack_go = dev_match(q.shift, q.pin_s2[2:0]);
								next_q.kind   = q.shift[4] ? SEW_K_PARAM : SEW_K_ARRAY;
								next_q.st     = SEW_ACK_DEV;
							end
							SEW_ADDR_HI: begin
								next_q.ahi = q.shift;
								next_q.st  = SEW_ACK_HI;
							end
							SEW_ADDR_LO: begin
								next_q.st    = SEW_ACK_LO;
								next_q.first = 1'b1;
								next_q.mask  = '0;
								if (q.kind == SEW_K_ARRAY) begin
									next_q.addr = {q.ahi[5:0], q.shift};
								end else begin
									next_q.addr = {8'h00, q.shift[5:0]};
									unique case (q.ahi[`SEW_REGION_MSB:`SEW_REGION_LSB])
										`SEW_REGION_PAGE: next_q.kind = SEW_K_PARAM;
										`SEW_REGION_LOCK: next_q.kind = SEW_K_LOCK;
										default:          next_q.kind = SEW_K_NONE;
									endcase
								end
							end
							default: begin
								next_q.st    = SEW_ACK_DATA;
								next_q.first = 1'b0;
								next_q.addr  = page_inc(q.addr);
								unique case (q.kind)
									SEW_K_ARRAY, SEW_K_PARAM: begin
										// first byte nacks under guard, later ones ack
										next_q.ack_go = !(guard && q.first) &&
											!(q.kind == SEW_K_PARAM && lock_state_i);
										if (!guard && !(q.kind == SEW_K_PARAM && lock_state_i)) begin
											next_q.page[q.addr[5:0]] = q.shift;
											next_q.mask[q.addr[5:0]] = 1'b1;
										end
									end
									SEW_K_LOCK: begin
										next_q.ack_go = q.first && !guard && !lock_state_i &&
											q.shift[`SEW_LOCK_BIT];
										next_q.lock_arm = q.first && !guard && !lock_state_i &&
											q.shift[`SEW_LOCK_BIT];
									end
									SEW_K_NONE: begin
										next_q.ack_go = 1'b0;
									end
								endcase
							end
						endcase
					end
				end
				SEW_ACK_DEV, SEW_ACK_HI, SEW_ACK_LO, SEW_ACK_DATA: begin
					if (scl_fall) begin
						next_q.drive  = 1'b0;
						next_q.bitcnt = 4'h0;
						if (!q.ack_go) begin
							next_q.st       = SEW_IDLE;
							next_q.mask     = '0;
							next_q.lock_arm = 1'b0;
						end else begin
							unique case (q.st)
								SEW_ACK_DEV: next_q.st = SEW_ADDR_HI;
								SEW_ACK_HI:  next_q.st = SEW_ADDR_LO;
								default:     next_q.st = SEW_DATA;
							endcase
						end
					end else begin
						next_q.drive = q.ack_go;
					end
				end
				SEW_PROG: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	// open drain: only ever pull low
	assign sda_o    = 1'b0;
	assign sda_oe_o = q.drive;
	assign busy_o   = (q.st == SEW_PROG);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (sys_rst_i);

	sequence s_launch_stop;
		q.st == SEW_DATA && q.bitcnt == 4'h1 && !q.shift[0] && stop_evt && launchable;
	endsequence

	a_dev_ack_match: assert property (
		byte_done && q.st == SEW_DEVADDR && dev_match(q.shift, q.pin_s2[2:0])
		|=> ##1 sda_oe_o)
		else $error("matching address byte not acknowledged");
	a_prog_launch: assert property (s_launch_stop |=> busy_o)
		else $error("valid stop did not launch programming");
	a_prog_cause: assert property ($rose(busy_o) |-> $past(stop_evt))
		else $error("programming began without a stop");
	a_prog_silent: assert property (busy_o |-> !sda_oe_o)
		else $error("bus driven during programming");
	a_addr_wrap: assert property (
		byte_done && q.st == SEW_DATA |=> q.addr[13:6] == $past(q.addr[13:6]) &&
		q.addr[5:0] == 6'($past(q.addr[5:0]) + 6'h1))
		else $error("address did not wrap inside page");
	a_guard_no_store: assert property (
		byte_done && q.st == SEW_DATA && guard |=> $stable(q.mask))
		else $error("byte stored while guard high");
	a_guard_first_nack: assert property (
		byte_done && q.st == SEW_DATA && q.first && guard |=> ##1 !sda_oe_o)
		else $error("guarded first data byte acknowledged");
	a_lock_refuse: assert property (
		byte_done && q.st == SEW_DATA && lock_state_i && q.kind != SEW_K_ARRAY
		|=> ##1 !sda_oe_o)
		else $error("data acknowledged to locked page");
	a_timer_length: assert property (
		$fell(busy_o) |-> $past(q.tmr) == 24'(PROG_CYCLES - 1))
		else $error("program cycle ended before timer");

endmodule : sew_write_engine

// ### shared/sew_defines.svh
// constants of the serial eeprom write engine
`ifndef SEW_DEFINES_SVH
`define SEW_DEFINES_SVH

// ----------------------------------------
// device address byte
// ----------------------------------------
`define SEW_TYPE_ARRAY   4'ha
`define SEW_TYPE_PARAM   4'hb
`define SEW_RW_BIT       0
`define SEW_TYPE_MSB     7
`define SEW_TYPE_LSB     4

// ----------------------------------------
// word address and data fields
// ----------------------------------------
`define SEW_REGION_MSB   2
`define SEW_REGION_LSB   1
`define SEW_REGION_PAGE  2'h0
`define SEW_REGION_LOCK  2'h2
`define SEW_LOCK_BIT     1
`define SEW_PAGE_BYTES   7'h40
`define SEW_BYTE_BITS    4'h8

// ----------------------------------------
// timing
// ----------------------------------------
`define SEW_CLK_PERIOD_NS 5
`define SEW_PROG_TIME_NS  1000000
`define SEW_PROG_CYCLES   (`SEW_PROG_TIME_NS / `SEW_CLK_PERIOD_NS)

`endif

// ### shared/sew_pkg.sv
// types of the serial eeprom write engine
package sew_pkg;

	typedef enum logic [1:0] {
		SEW_K_ARRAY,
		SEW_K_PARAM,
		SEW_K_LOCK,
		SEW_K_NONE
	} sew_kind_t;

	typedef struct packed {
		sew_kind_t   kind;
		logic [13:0] addr;
		logic [7:0]  data;
	} sew_wr_t;

	typedef enum logic [3:0] {
		SEW_IDLE,
		SEW_DEVADDR,
		SEW_ACK_DEV,
		SEW_ADDR_HI,
		SEW_ACK_HI,
		SEW_ADDR_LO,
		SEW_ACK_LO,
		SEW_DATA,
		SEW_ACK_DATA,
		SEW_PROG
	} sew_st_t;

	typedef struct packed {
		logic            scl_s1;
		logic            scl_s2;
		logic            scl_d;
		logic            sda_s1;
		logic            sda_s2;
		logic            sda_d;
		logic [3:0]      pin_s1;
		logic [3:0]      pin_s2;
		sew_st_t         st;
		logic [3:0]      bitcnt;
		logic [7:0]      shift;
		logic [7:0]      ahi;
		sew_kind_t       kind;
		logic [13:0]     addr;
		logic            first;
		logic            ack_go;
		logic            drive;
		logic            lock_arm;
		logic [63:0]     mask;
		logic [63:0][7:0] page;
		logic [6:0]      idx;
		logic [23:0]     tmr;
	} sew_eng_t;

	typedef struct packed {
		sew_wr_t [1:0] slot;
		logic [1:0]    cnt;
		logic          wr;
		logic          rd;
	} sew_buf_t;

endpackage : sew_pkg

// ### hdl/sew_buf2.sv
// two-entry buffer between the program sequencer and the array port
`timescale 1ns/1ps
module sew_buf2 (
	input  wire logic            clock_i,
	input  wire logic            sys_rst_i,
	input  wire logic            in_valid_i,
	output logic                 in_ready_o,
	input  wire sew_pkg::sew_wr_t in_word_i,
	output logic                 out_valid_o,
	input  wire logic            out_ready_i,
	output sew_pkg::sew_wr_t     out_word_o
);
	import sew_pkg::*;

	sew_buf_t q;
	sew_buf_t next_q;
	logic     push;
	logic     pop;

	assign in_ready_o  = (q.cnt != 2'h2);
	assign out_valid_o = (q.cnt != 2'h0);
	assign out_word_o  = q.slot[q.rd];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always_comb begin
		next_q = q;
		if (push) begin
			next_q.slot[q.wr] = in_word_i;
			next_q.wr         = ~q.wr;
		end
		if (pop) begin
			next_q.rd = ~q.rd;
		end
		next_q.cnt = 2'(q.cnt + {1'b0, push} - {1'b0, pop});
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	a_buf_full_stall: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		q.cnt == 2'h2 |-> !in_ready_o)
		else $error("buffer takes a word while full");
	a_buf_hold_word: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_word_o))
		else $error("stalled output word changed");

endmodule : sew_buf2

// ### dv/sew_master_model.sv
// two-wire bus master model that drives the write engine's pins
`timescale 1ns/1ps
module sew_master_model (
	input  wire logic clock_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	// scl idles high, driven by the model, and stays driven high between frames
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask : tick
	// also serves a repeated start, so scl may enter low
	task automatic start();
		sda_o <= 1'b1;
		tick(4);
		scl_o <= 1'b1;
		tick(8);
		sda_o <= 1'b0;
		tick(8);
		scl_o <= 1'b0;
	endtask : start
	// data moves only while scl is low; 16 clocks per bit
	task automatic clk_bit(input logic b, output logic s);
		tick(4);
		sda_o <= b;
		tick(4);
		scl_o <= 1'b1;
		tick(4);
		s = sda_i;
		tick(4);
		scl_o <= 1'b0;
	endtask : clk_bit
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(b[i], s);
		end
		clk_bit(1'b1, s);
		ack = ~s;
	endtask : send_byte
	// stop in the slot after an acked data byte launches programming
	task automatic stop();
		tick(4);
		sda_o <= 1'b0;
		tick(4);
		scl_o <= 1'b1;
		tick(8);
		sda_o <= 1'b1;
		tick(8);
	endtask : stop
endmodule : sew_master_model

// ### dv/sew_write_engine_test.sv
// self-checking bench of the serial eeprom write engine
`timescale 1ns/1ps
module sew_write_engine_test;
	import sew_pkg::*;
	localparam int PROG = 400;
	logic        clock_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        m_scl, m_sda, sda_o, sda_oe_o, busy, nv_valid;
	logic        guard = 1'b0;
	logic        lock_state = 1'b0;
	logic        nv_ready = 1'b1;
	logic [2:0]  strap = 3'h5;
	sew_wr_t     nv_word;
	logic [23:0] got[$];
	logic [23:0] q[$];
	int          errors = 0;
	int          compares = 0;
	// open drain: pull-up unless a party pulls low
	wire sda_w = m_sda & ~(sda_oe_o & ~sda_o);
	always #2.5 clock_i = ~clock_i;
	// array port and lock storage stand in for the non-volatile side
	always @(posedge clock_i) begin
		if (nv_valid && nv_ready) begin
			got.push_back(nv_word);
			if (nv_word.kind === SEW_K_LOCK) lock_state <= 1'b1;
		end
	end
	sew_master_model sew_master_model_i (.clock_i(clock_i), .sda_i(sda_w),
		.scl_o(m_scl), .sda_o(m_sda));
	sew_write_engine #(.PROG_CYCLES(PROG)) sew_write_engine_i (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .scl_i(m_scl), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe_o(sda_oe_o), .strap_address_bit0_i(strap[0]),
		.strap_address_bit1_i(strap[1]), .strap_address_bit2_i(strap[2]),
		.write_guard_i(guard), .lock_state_i(lock_state), .busy_o(busy),
		.nv_valid_o(nv_valid), .nv_ready_i(nv_ready), .nv_word_o(nv_word));
	task automatic chk_bit(input string w, input logic e, input logic g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %b seen %b", w, e, g);
		end
	endtask : chk_bit
	task automatic chk_word(input string w, input logic [23:0] e, input logic [23:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", w, e, g);
		end
	endtask : chk_word
	task automatic xfer(input logic [7:0] b, input logic e, input string w);
		logic a;
		sew_master_model_i.send_byte(b, a);
		chk_bit(w, e, a);
	endtask : xfer
	task automatic head(input logic [3:0] ty, input logic [15:0] wa);
		sew_master_model_i.start();
		xfer({ty, strap, 1'b0}, 1'b1, "dev ack");
		xfer(wa[15:8], 1'b1, "hi ack");
		xfer(wa[7:0], 1'b1, "lo ack");
	endtask : head
	task automatic stop_chk(input logic e);
		sew_master_model_i.stop();
		@(negedge clock_i);
		chk_bit("busy", e, busy);
		@(posedge clock_i);
	endtask : stop_chk
	// bounded wait; a stalled array port keeps busy up
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 3000) begin
			@(negedge clock_i);
			n++;
		end
		chk_bit("busy end", 1'b0, busy);
		@(posedge clock_i);
	endtask : wait_idle
	task automatic chk_words(input logic [23:0] m);
		chk_word("count", 24'(q.size()), 24'(got.size()));
		foreach (q[k]) begin
			if (k < got.size()) chk_word("nv word", q[k] & m, got[k] & m);
		end
		got.delete();
		q.delete();
	endtask : chk_words
	task automatic t_refuse();
		logic [7:0] bad[3];
		bad = '{{4'h9, strap, 1'b0}, {4'ha, ~strap, 1'b0}, {4'ha, strap, 1'b1}};
		foreach (bad[k]) begin
			sew_master_model_i.start();
			xfer(bad[k], 1'b0, "bad dev");
			sew_master_model_i.stop();
		end
		head(4'ha, 16'h0010);
		chk_bit("sda level", 1'b0, sda_o);
		stop_chk(1'b0);
		chk_words(24'hffffff);
		$display("refuse done");
	endtask : t_refuse
	task automatic t_byte();
		head(4'ha, 16'h0123);
		xfer(8'h5a, 1'b1, "data ack");
		stop_chk(1'b1);
		sew_master_model_i.start();
		xfer({4'ha, strap, 1'b0}, 1'b0, "poll busy");
		sew_master_model_i.stop();
		wait_idle();
		sew_master_model_i.start();
		xfer({4'ha, strap, 1'b0}, 1'b1, "poll done");
		stop_chk(1'b0);
		q.push_back({SEW_K_ARRAY, 14'h0123, 8'h5a});
		chk_words(24'hffffff);
		$display("byte write done");
	endtask : t_byte
	task automatic t_guard();
		guard <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			head(k ? 4'hb : 4'ha, 16'h0005);
			xfer(8'h11, 1'b0, "guard nack");
			stop_chk(1'b0);
		end
		chk_words(24'hffffff);
		guard <= 1'b0;
		$display("guard done");
	endtask : t_guard
	// 66 bytes from offset 62: wraps and overwrites 62 and 63
	task automatic t_page();
		nv_ready <= 1'b0;
		head(4'ha, 16'h0a7e);
		for (int i = 0; i < 66; i++) begin
			xfer(8'h40 + 8'(i), 1'b1, "page ack");
		end
		stop_chk(1'b1);
		sew_master_model_i.tick(PROG + 50);
		chk_bit("stall busy", 1'b1, busy);
		chk_bit("stall valid", 1'b1, nv_valid);
		nv_ready <= 1'b1;
		wait_idle();
		for (int o = 0; o < 64; o++) begin
			q.push_back({SEW_K_ARRAY, 8'h29, 6'(o), 8'h40 + 8'(o + 2)});
		end
		chk_words(24'hffffff);
		$display("page write done");
	endtask : t_page
	task automatic t_param();
		head(4'hb, 16'h0005);
		xfer(8'ha1, 1'b1, "param ack");
		xfer(8'ha2, 1'b1, "param ack");
		stop_chk(1'b1);
		wait_idle();
		q.push_back({SEW_K_PARAM, 14'h0005, 8'ha1});
		q.push_back({SEW_K_PARAM, 14'h0006, 8'ha2});
		chk_words(24'hc03fff);
		head(4'hb, 16'h0400);
		xfer(8'hfd, 1'b0, "lock bit clear");
		sew_master_model_i.stop();
		head(4'hb, 16'h0400);
		xfer(8'h02, 1'b1, "lock ack");
		stop_chk(1'b1);
		wait_idle();
		q.push_back({SEW_K_LOCK, 14'h0000, 8'h02});
		chk_words(24'hc000ff);
		head(4'hb, 16'h0001);
		xfer(8'h33, 1'b0, "locked nack");
		stop_chk(1'b0);
		head(4'hb, 16'h0400);
		xfer(8'h02, 1'b0, "relock nack");
		stop_chk(1'b0);
		chk_words(24'hffffff);
		$display("parameter page done");
	endtask : t_param
	task automatic stop_test();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test
	// about 20k clocks expected; cut off at 60k clocks
	initial begin
		#300000;
		errors++;
		stop_test();
	end
	initial begin
		repeat (6) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		repeat (4) @(posedge clock_i);
		t_refuse();
		t_byte();
		t_guard();
		t_page();
		t_param();
		stop_test();
	end
endmodule : sew_write_engine_test
